// File: hdl/pms_pkg.sv
/*
 Shared constants, field layout and helper functions of the modem's serial host port.
 Assumes both the device end and the host end import it whole.
*/
package pms_pkg;

    // Operation codes, first byte of every transaction, then the dummy byte value
    localparam logic [7:0]  OP_READ      = 8'h63;
    localparam logic [7:0]  OP_WRITE     = 8'h2A;
    localparam logic [7:0]  OP_AND       = 8'h4C;
    localparam logic [7:0]  OP_OR        = 8'h71;
    localparam logic [7:0]  OP_XOR       = 8'h6D;
    localparam logic [7:0]  OP_WREP      = 8'h1E;
    localparam logic [7:0]  DUMMY_BYTE   = 8'h00;

    // Physical-layer special function register, bit 0 mirrors the interrupt pin
    localparam logic [15:0] SFR_ADDR     = 16'hFE2A;
    localparam logic [7:0]  SFR_RESET    = 8'h87;
    localparam int          SFR_INT_BIT  = 0;

    // Byte positions inside a transaction
    localparam logic [8:0]  IDX_OP       = 9'h000;
    localparam logic [8:0]  IDX_ADDR_HI  = 9'h001;
    localparam logic [8:0]  IDX_ADDR_LO  = 9'h002;
    localparam logic [8:0]  IDX_DUMMY    = 9'h003;

    // Crossing FIFO entry: {op, addr, data}
    localparam int          ENT_W        = 32;
    localparam int          ENT_OP_LSB   = 24;
    localparam int          ENT_ADDR_LSB = 8;
    localparam int          ENT_DATA_LSB = 0;
    localparam int          FIFO_DEPTH   = 16;

    // Timing: host serial clock kept at or below the advised ceiling
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          SCK_MAX_HZ   = 10_000_000;
    localparam int          SCK_MIN_DIV  = (CLK_HZ + SCK_MAX_HZ - 1) / SCK_MAX_HZ;
    // Half period in clk cycles; twice the minimum leaves room for the miso synchroniser
    localparam int          SCK_HALF_CYC = SCK_MIN_DIV;

    function automatic logic op_is_mask(input logic [7:0] op);
        return (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
    endfunction : op_is_mask

    function automatic logic op_is_known(input logic [7:0] op);
        return (op == OP_READ) || (op == OP_WRITE) || (op == OP_WREP) || op_is_mask(op);
    endfunction : op_is_known

    function automatic logic [7:0] mask_apply(input logic [7:0] op,
                                              input logic [7:0] cur,
                                              input logic [7:0] arg);
        logic [7:0] res;
        res = cur;
        if (op == OP_AND) begin
            res = cur & arg;
        end else if (op == OP_OR) begin
            res = cur | arg;
        end else if (op == OP_XOR) begin
            res = cur ^ arg;
        end
        return res;
    endfunction : mask_apply

endpackage : pms_pkg

// File: hdl/pms_spi_if.sv
/*
 Serial link between host and modem port: select, clock, data both ways, interrupt.
 Assumes the bench resolves miso from miso_oe; nothing here resolves levels.
*/
`timescale 1ns/1ps
interface pms_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic host_interrupt_n;

    modport host (
        output cs_n,
        output sck,
        output mosi,
        input  miso,
        input  miso_oe,
        input  host_interrupt_n
    );

    modport dev (
        input  cs_n,
        input  sck,
        input  mosi,
        output miso,
        output miso_oe,
        output host_interrupt_n
    );
endinterface : pms_spi_if

// File: hdl/pms_dev.sv
/*
 Device end of the serial host port: link-clocked shifter, gray-pointer crossing FIFO,
 and a clk-domain executor that drives a memory bus and holds the interrupt flag.
 Assumes the host is the only master and that sck stays at or below 10 MHz.
*/
// Contract
// - Device is slave, never drives sck/select
// - Select high: ignore sck and mosi
// - Device samples mosi on rising sck
// - Device changes miso on falling sck
// - Host keeps sck at most 10 MHz
// - Active-low interrupt pin, separate from link
// - Received frame: header and end interrupts
// - Sent frame raises one interrupt
// - First byte after select is opcode
// - Decode read, write, repeated write codes
// - Decode AND, OR, XOR mask codes
// - Bytes two, three: 16-bit address
// - One dummy byte, content discarded
// - Pin mirrors flag; write one clears
`timescale 1ns/1ps
module pms_afifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         wclk,
    input  wire logic         wrst,
    input  wire logic         w_valid,
    input  wire logic [W-1:0] w_data,
    output logic              w_ready,
    input  wire logic         rclk,
    input  wire logic         rrst,
    output logic              r_valid,
    output logic [W-1:0]      r_data,
    input  wire logic         r_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wbin_r, wbin_nxt, wgray_r, wgray_nxt;
    logic [AW:0]  rbin_r, rbin_nxt, rgray_r, rgray_nxt;
    logic [AW:0]  rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    // Full when write gray equals read gray with the top two bits inverted
    assign w_ready = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
    assign r_valid = (rgray_r != wg_s2_r);
    assign r_data  = mem_r[rbin_r[AW-1:0]];

    always_comb begin
        wbin_nxt  = wbin_r + {{AW{1'b0}}, (w_valid && w_ready)};
        wgray_nxt = to_gray(wbin_nxt);
        rbin_nxt  = rbin_r + {{AW{1'b0}}, (r_valid && r_ready)};
        rgray_nxt = to_gray(rbin_nxt);
    end

    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem_r[wbin_r[AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge wclk or posedge wrst) begin
        if (wrst) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wgray_nxt;
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    always_ff @(posedge rclk or posedge rrst) begin
        if (rrst) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rgray_nxt;
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
        end
    end
endmodule : pms_afifo

module pms_dev
    import pms_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic  clk,
    input  wire logic  reset,
    input  wire logic  rx_header_evt,
    input  wire logic  rx_frame_evt,
    input  wire logic  tx_frame_evt,
    output logic       mem_req,
    output logic       mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input  wire logic [7:0] mem_rdata,
    input  wire logic  mem_gnt,
    pms_spi_if.dev     link
);
    typedef enum logic [5:0] {
        LS_OP   = 6'h01,
        LS_AH   = 6'h02,
        LS_AL   = 6'h04,
        LS_DUM  = 6'h08,
        LS_DATA = 6'h10,
        LS_IGN  = 6'h20
    } pms_lstate_t;

    typedef enum logic [3:0] {
        CS_IDLE  = 4'h1,
        CS_READ  = 4'h2,
        CS_RWAIT = 4'h4,
        CS_WRITE = 4'h8
    } pms_cstate_t;

    // Link domain; select high holds it in reset, so a partial byte is dropped but whole bytes already queued still execute
    logic              lrst;
    pms_lstate_t       ls_r, ls_nxt;
    logic [2:0]        bit_r, bit_nxt;
    logic [6:0]        rx_sh_r, rx_sh_nxt;
    logic [7:0]        op_r, op_nxt;
    logic [15:0]       addr_r, addr_nxt;
    logic [7:0]        tx_sh_r, tx_sh_nxt;
    logic              miso_r;
    logic [7:0]        byte_in;
    logic              push;
    logic [15:0]       push_addr;
    logic [ENT_W-1:0]  push_ent;

    // Clk domain
    pms_cstate_t       cs_r, cs_nxt;
    logic [7:0]        cmd_op_r, cmd_op_nxt;
    logic [15:0]       cmd_addr_r, cmd_addr_nxt;
    logic [7:0]        cmd_data_r, cmd_data_nxt;
    logic [7:0]        rd_data_r, rd_data_nxt;
    logic              int_flag_r, int_flag_nxt;
    logic              pop_valid;
    logic [ENT_W-1:0]  pop_ent;
    logic              pop;
    logic              is_sfr;
    logic [7:0]        sfr_val;
    logic [7:0]        src;
    logic              fin;

    assign lrst = reset | link.cs_n;
    assign byte_in = {rx_sh_r, link.mosi};
    assign push_ent = {op_r, push_addr, byte_in};

    always_comb begin
        ls_nxt    = ls_r;
        bit_nxt   = bit_r + 3'h1;
        rx_sh_nxt = byte_in[6:0];
        op_nxt    = op_r;
        addr_nxt  = addr_r;
        tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
        push      = 1'b0;
        push_addr = addr_r;
        if (bit_r == 3'h7) begin
            unique case (ls_r)
                LS_OP: begin
                    op_nxt = byte_in;
                    ls_nxt = op_is_known(byte_in) ? LS_AH : LS_IGN;
                end
                LS_AH: begin
                    addr_nxt = {byte_in, addr_r[7:0]};
                    ls_nxt   = LS_AL;
                end
                LS_AL: begin
                    addr_nxt = {addr_r[15:8], byte_in};
                    ls_nxt   = LS_DUM;
                    // Fetch early: the dummy byte gives the clk side a whole byte time
                    push      = (op_r == OP_READ);
                    push_addr = addr_nxt;
                end
                LS_DUM, LS_DATA: begin
                    ls_nxt = LS_DATA;
                    if (op_r == OP_READ) begin
                        // Quasi-static: the fetch ends well inside one byte time at the advised sck
                        tx_sh_nxt = rd_data_r;
                        addr_nxt  = addr_r + 16'h0001;
                        push      = 1'b1;
                        push_addr = addr_nxt;
                    end else if (ls_r == LS_DATA) begin
                        push     = 1'b1;
                        addr_nxt = (op_r == OP_WREP) ? addr_r : addr_r + 16'h0001;
                    end
                end
                LS_IGN: begin
                end
            endcase
        end
    end

    always_ff @(posedge link.sck or posedge lrst) begin
        if (lrst) begin
            ls_r    <= LS_OP;
            bit_r   <= 3'h0;
            rx_sh_r <= 7'h00;
            op_r    <= 8'h00;
            addr_r  <= 16'h0000;
            tx_sh_r <= 8'h00;
        end else begin
            ls_r    <= ls_nxt;
            bit_r   <= bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            op_r    <= op_nxt;
            addr_r  <= addr_nxt;
            tx_sh_r <= tx_sh_nxt;
        end
    end

    always_ff @(negedge link.sck or posedge lrst) begin
        if (lrst) begin
            miso_r <= 1'b0;
        end else begin
            miso_r <= tx_sh_r[7];
        end
    end

    // Data and its enable leave; select and clock stay inputs
    assign link.miso    = miso_r;
    assign link.miso_oe = ~link.cs_n;

    // The link cannot be stalled; a byte arriving while full is dropped
    pms_afifo #(
        .W     (ENT_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .wclk    (link.sck),
        .wrst    (reset),
        .w_valid (push),
        .w_data  (push_ent),
        .w_ready (),
        .rclk    (clk),
        .rrst    (reset),
        .r_valid (pop_valid),
        .r_data  (pop_ent),
        .r_ready (pop)
    );

    assign is_sfr  = (cmd_addr_r == SFR_ADDR);
    assign sfr_val = {SFR_RESET[7:1], int_flag_r};
    assign src     = is_sfr ? sfr_val : mem_rdata;
    assign fin     = ((cs_r == CS_READ) && is_sfr) || (cs_r == CS_RWAIT);

    always_comb begin
        cs_nxt       = cs_r;
        cmd_op_nxt   = cmd_op_r;
        cmd_addr_nxt = cmd_addr_r;
        cmd_data_nxt = cmd_data_r;
        rd_data_nxt  = rd_data_r;
        int_flag_nxt = int_flag_r;
        pop          = 1'b0;
        mem_req      = 1'b0;
        mem_we       = 1'b0;
        unique case (cs_r)
            CS_IDLE: begin
                pop = 1'b1;
                if (pop_valid) begin
                    cmd_op_nxt   = pop_ent[ENT_OP_LSB +: 8];
                    cmd_addr_nxt = pop_ent[ENT_ADDR_LSB +: 16];
                    cmd_data_nxt = pop_ent[ENT_DATA_LSB +: 8];
                    cs_nxt = ((cmd_op_nxt == OP_READ) || op_is_mask(cmd_op_nxt)) ? CS_READ : CS_WRITE;
                end
            end
            CS_READ: begin
                if (!is_sfr) begin
                    mem_req = 1'b1;
                    if (mem_gnt) begin
                        cs_nxt = CS_RWAIT;
                    end
                end
            end
            CS_RWAIT: begin
            end
            CS_WRITE: begin
                if (is_sfr) begin
                    if (cmd_data_r[SFR_INT_BIT]) begin
                        int_flag_nxt = 1'b1;
                    end
                    cs_nxt = CS_IDLE;
                end else begin
                    mem_req = 1'b1;
                    mem_we  = 1'b1;
                    if (mem_gnt) begin
                        cs_nxt = CS_IDLE;
                    end
                end
            end
        endcase
        if (fin) begin
            if (cmd_op_r == OP_READ) begin
                rd_data_nxt = src;
                cs_nxt      = CS_IDLE;
            end else begin
                cmd_data_nxt = mask_apply(cmd_op_r, src, cmd_data_r);
                cs_nxt       = CS_WRITE;
            end
        end
        // An event in the same cycle as a host clear keeps the interrupt pending
        if (rx_header_evt || rx_frame_evt || tx_frame_evt) begin
            int_flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_r       <= CS_IDLE;
            cmd_op_r   <= 8'h00;
            cmd_addr_r <= 16'h0000;
            cmd_data_r <= 8'h00;
            rd_data_r  <= 8'h00;
            int_flag_r <= SFR_RESET[SFR_INT_BIT];
        end else begin
            cs_r       <= cs_nxt;
            cmd_op_r   <= cmd_op_nxt;
            cmd_addr_r <= cmd_addr_nxt;
            cmd_data_r <= cmd_data_nxt;
            rd_data_r  <= rd_data_nxt;
            int_flag_r <= int_flag_nxt;
        end
    end

    assign mem_addr              = cmd_addr_r;
    assign mem_wdata             = cmd_data_r;
    assign link.host_interrupt_n = int_flag_r;
endmodule : pms_dev

// File: hdl/pms_host.sv
/*
 Host end of the serial port: serial clock made by dividing clk, one transaction per command,
 write data taken as a stream, read data returned as one-cycle pulses.
 Assumes the device samples on rising sck and shifts on falling sck.
*/
`timescale 1ns/1ps
module pms_host
    import pms_pkg::*;
#(
    parameter int HALF = SCK_HALF_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic [7:0] cmd_op,
    input  wire logic [15:0] cmd_addr,
    input  wire logic [7:0] cmd_len,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            irq,
    pms_spi_if.host         link
);
    typedef enum logic [3:0] {
        HS_IDLE  = 4'h1,
        HS_LOAD  = 4'h2,
        HS_SHIFT = 4'h4,
        HS_END   = 4'h8
    } pms_hstate_t;

    pms_hstate_t hs_r, hs_nxt;
    logic [7:0]  div_r, div_nxt;
    logic        sck_r, sck_nxt;
    logic        cs_n_r, cs_n_nxt;
    logic        mosi_r, mosi_nxt;
    logic [7:0]  tx_sh_r, tx_sh_nxt;
    logic [7:0]  rx_sh_r, rx_sh_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [8:0]  idx_r, idx_nxt;
    logic [7:0]  op_r, op_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0]  len_r, len_nxt;
    logic [7:0]  rx_data_r, rx_data_nxt;
    logic        rx_valid_r, rx_valid_nxt;
    logic        miso_s1_r, miso_s2_r, int_s1_r, int_s2_r;
    logic        tick;
    logic        have_byte;
    logic [7:0]  next_byte;

    assign tick = (div_r == 8'(HALF - 1));

    always_comb begin
        hs_nxt       = hs_r;
        div_nxt      = tick ? 8'h00 : div_r + 8'h01;
        sck_nxt      = sck_r;
        cs_n_nxt     = cs_n_r;
        mosi_nxt     = mosi_r;
        tx_sh_nxt    = tx_sh_r;
        rx_sh_nxt    = rx_sh_r;
        bit_nxt      = bit_r;
        idx_nxt      = idx_r;
        op_nxt       = op_r;
        addr_nxt     = addr_r;
        len_nxt      = len_r;
        rx_data_nxt  = rx_data_r;
        rx_valid_nxt = 1'b0;
        cmd_ready    = 1'b0;
        tx_ready     = 1'b0;
        have_byte    = 1'b1;
        next_byte    = DUMMY_BYTE;
        unique case (hs_r)
            HS_IDLE: begin
                cmd_ready = 1'b1;
                div_nxt   = 8'h00;
                if (cmd_valid) begin
                    op_nxt   = cmd_op;
                    addr_nxt = cmd_addr;
                    len_nxt  = cmd_len;
                    idx_nxt  = IDX_OP;
                    hs_nxt   = HS_LOAD;
                end
            end
            HS_LOAD: begin
                div_nxt = 8'h00;
                if (idx_r == IDX_OP) begin
                    next_byte = op_r;
                end else if (idx_r == IDX_ADDR_HI) begin
                    next_byte = addr_r[15:8];
                end else if (idx_r == IDX_ADDR_LO) begin
                    next_byte = addr_r[7:0];
                end else if (idx_r != IDX_DUMMY && op_r != OP_READ) begin
                    tx_ready  = 1'b1;
                    have_byte = tx_valid;
                    next_byte = tx_data;
                end
                if (have_byte) begin
                    tx_sh_nxt = next_byte;
                    mosi_nxt  = next_byte[7];
                    cs_n_nxt  = 1'b0;
                    bit_nxt   = 3'h0;
                    hs_nxt    = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                if (tick && !sck_r) begin
                    sck_nxt   = 1'b1;
                    rx_sh_nxt = {rx_sh_r[6:0], miso_s2_r};
                end else if (tick) begin
                    sck_nxt = 1'b0;
                    if (bit_r == 3'h7) begin
                        if (op_r == OP_READ && idx_r > IDX_DUMMY) begin
                            rx_data_nxt  = rx_sh_r;
                            rx_valid_nxt = 1'b1;
                        end
                        if (idx_r == {1'b0, len_r} + IDX_DUMMY) begin
                            hs_nxt = HS_END;
                        end else begin
                            idx_nxt = idx_r + 9'h001;
                            hs_nxt  = HS_LOAD;
                        end
                    end else begin
                        bit_nxt   = bit_r + 3'h1;
                        tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
                        mosi_nxt  = tx_sh_r[6];
                    end
                end
            end
            HS_END: begin
                if (tick) begin
                    cs_n_nxt = 1'b1;
                    hs_nxt   = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hs_r       <= HS_IDLE;
            div_r      <= 8'h00;
            sck_r      <= 1'b0;
            cs_n_r     <= 1'b1;
            mosi_r     <= 1'b0;
            tx_sh_r    <= 8'h00;
            rx_sh_r    <= 8'h00;
            bit_r      <= 3'h0;
            idx_r      <= 9'h000;
            op_r       <= 8'h00;
            addr_r     <= 16'h0000;
            len_r      <= 8'h00;
            rx_data_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            miso_s1_r  <= 1'b0;
            miso_s2_r  <= 1'b0;
            int_s1_r   <= 1'b1;
            int_s2_r   <= 1'b1;
        end else begin
            hs_r       <= hs_nxt;
            div_r      <= div_nxt;
            sck_r      <= sck_nxt;
            cs_n_r     <= cs_n_nxt;
            mosi_r     <= mosi_nxt;
            tx_sh_r    <= tx_sh_nxt;
            rx_sh_r    <= rx_sh_nxt;
            bit_r      <= bit_nxt;
            idx_r      <= idx_nxt;
            op_r       <= op_nxt;
            addr_r     <= addr_nxt;
            len_r      <= len_nxt;
            rx_data_r  <= rx_data_nxt;
            rx_valid_r <= rx_valid_nxt;
            miso_s1_r  <= link.miso;
            miso_s2_r  <= miso_s1_r;
            int_s1_r   <= link.host_interrupt_n;
            int_s2_r   <= int_s1_r;
        end
    end

    // The sck rate is set by HALF; at least SCK_MIN_DIV/2 keeps within 10 MHz
    assign link.cs_n = cs_n_r;
    assign link.sck  = sck_r;
    assign link.mosi = mosi_r;
    assign rx_data   = rx_data_r;
    assign rx_valid  = rx_valid_r;
    assign irq       = ~int_s2_r;
endmodule : pms_host

// File: tb/pms_link_monitor.sv
/* Checker on the serial lines between the two ends of the port.
   Assumes the host runs with four clk cycles per sck half period. */
`timescale 1ns/1ps
module pms_link_monitor (
    input logic clk,
    input logic reset,
    input logic cs_n,
    input logic sck,
    input logic mosi,
    input logic miso,
    input logic miso_oe,
    input logic host_interrupt_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic       sck_q_r;
    logic [7:0] n_r;
    logic [7:0] n_nxt;
    // Rising sck edges in the current frame, so partial bytes show up at deselect
    always_comb n_nxt = cs_n ? 8'h00 : n_r + {7'h00, sck & !sck_q_r};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_q_r <= 1'b0;
            n_r     <= 8'h00;
        end else begin
            sck_q_r <= sck;
            n_r     <= n_nxt;
        end
    end
    oe_select_a: assert property (miso_oe == !cs_n) else $error("miso_oe off");
    miso_idle_a: assert property (cs_n |-> !miso) else $error("miso busy idle");
    miso_edge_a: assert property (!cs_n && $changed(miso) |-> $fell(sck)) else $error("miso edge");
    sck_idle_a: assert property (cs_n |-> !sck) else $error("sck idle");
    sck_high_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck) else $error("sck high");
    sck_low_a: assert property ($fell(sck) |-> !sck[*4]) else $error("sck low");
    mosi_hold_a: assert property ($rose(sck) |-> !cs_n && $stable(mosi) ##1 $stable(mosi)) else $error("mosi");
    frame_bytes_a: assert property ($rose(cs_n) |-> n_r[2:0] == 3'h0 && n_r >= 8'h20) else $error("frame");
endmodule : pms_link_monitor

// File: tb/plc_modem_spi_host_port_tb_top.sv
/* Bench: host and device ends joined by the link, a byte memory on the device bus.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
module plc_modem_spi_host_port_tb_top;
    import pms_pkg::*;
    logic        clk = 0, reset = 1, cmd_valid = 0, tx_valid = 0, cmd_ready, tx_ready, rx_valid, irq;
    logic        mem_req, mem_we, mem_gnt;
    logic [2:0]  ev = 3'h0;
    logic [7:0]  cmd_op = 8'h00, cmd_len = 8'h00, tx_data = 8'h00, got = 8'h00, mem_rdata = 8'h00;
    logic [7:0]  rx_data, mem_wdata;
    logic [15:0] cmd_addr = 16'h0000, mem_addr;
    logic [7:0]  mem [0:65535] = '{default: 8'h00};
    logic [7:0]  ops [3] = '{OP_AND, OP_OR, OP_XOR};
    logic [7:0]  exp_m [3] = '{8'h30, 8'hFC, 8'hCC};
    int          n_errors = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    // Grant at once; the device still has to sample read data a cycle later
    assign mem_gnt = mem_req;
    always @(posedge clk) begin
        if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_req && !mem_we) mem_rdata <= mem[mem_addr];
        if (rx_valid) got <= rx_data;
        if (tx_valid && tx_ready) tx_data <= tx_data + 8'h11;
    end
    pms_spi_if lk ();
    pms_host pms_host_inst (.clk, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_len, .tx_valid,
        .tx_ready, .tx_data, .rx_valid, .rx_data, .irq, .link(lk.host));
    pms_dev pms_dev_inst (.clk, .reset, .rx_header_evt(ev[0]), .rx_frame_evt(ev[1]), .tx_frame_evt(ev[2]),
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_gnt, .link(lk.dev));
    pms_link_monitor pms_link_monitor_inst (.clk, .reset, .cs_n(lk.cs_n), .sck(lk.sck), .mosi(lk.mosi),
        .miso(lk.miso), .miso_oe(lk.miso_oe), .host_interrupt_n(lk.host_interrupt_n));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] op, input logic [15:0] a, input logic [7:0] n, input logic [7:0] d);
        int k;
        @(negedge clk);
        {cmd_op, cmd_addr, cmd_len, tx_data, got, cmd_valid, tx_valid} = {op, a, n, d, 8'h00, 2'b11};
        @(negedge clk);
        cmd_valid = 0;
        for (k = 0; k < 3000 && cmd_ready !== 1'b1; k++) @(negedge clk);
        tx_valid = 0;
        chk("done", 8'h01, {7'h00, cmd_ready});
        // Leaves time for the queued entry to cross and reach the memory
        repeat (20) @(negedge clk);
        $display("transfer %h at %h done", op, a);
    endtask : xfer
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(negedge clk);
        reset = 0;
        xfer(OP_WRITE, 16'h1234, 8'h02, 8'h5A);
        chk("wr", 8'h5A, mem[16'h1234]);
        chk("wr inc", 8'h6B, mem[16'h1235]);
        xfer(OP_WREP, 16'h0020, 8'h02, 8'hA0);
        chk("rep", 8'hB1, mem[16'h0020]);
        chk("rep hold", 8'h00, mem[16'h0021]);
        xfer(OP_READ, 16'h1234, 8'h01, 8'h00);
        chk("rd", 8'h5A, got);
        xfer(8'h55, 16'h0040, 8'h01, 8'h77);
        chk("bad op", 8'h00, mem[16'h0040]);
        for (int j = 0; j < 3; j++) begin
            xfer(OP_WRITE, 16'h0050, 8'h01, 8'hF0);
            xfer(ops[j], 16'h0050, 8'h01, 8'h3C);
            chk("mask", exp_m[j], mem[16'h0050]);
        end
        for (int j = 0; j < 3; j++) begin
            chk("irq idle", 8'h00, {7'h00, irq});
            ev[j] = 1'b1;
            @(negedge clk);
            ev = 3'h0;
            repeat (8) @(negedge clk);
            chk("irq", 8'h01, {7'h00, irq});
            xfer(OP_READ, SFR_ADDR, 8'h01, 8'h00);
            chk("sfr", {SFR_RESET[7:1], 1'b0}, got);
            xfer(OP_WRITE, SFR_ADDR, 8'h01, 8'h01);
            chk("irq clr", 8'h00, {7'h00, irq});
        end
        print_verdict();
    end
    initial begin
        #600000;
        n_errors++;
        print_verdict();
    end
endmodule : plc_modem_spi_host_port_tb_top
